// File: dv/i2c_peer.sv
// Behavioural bus controller that faces the block on the two wires
`timescale 1ns/1ps
module i2c_peer (
    output logic scl,
    output logic sda_low,
    input  wire  sda
);
    // Idle bus: clock high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Start condition when first is set, else stop; clock is left low after a start and high after a stop
    task automatic cond(input logic first);
        sda_low = !first;
        #50 scl = 1'b1;
        #50 sda_low = first;
        #50 scl = !first;
        #50;
    endtask
    // Eight bits msb first then the acknowledge clock; data moves only while clock is low
    task automatic xfer(input logic [7:0] tx, input logic ack_in,
                        output logic [7:0] rx, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_low = (i > 0) ? !tx[i-1] : !ack_in;
            #50 scl = 1'b1;
            #50 if (i > 0) rx[i-1] = sda; else ack = sda;
            #50 scl = 1'b0;
            #50;
        end
        sda_low = 1'b0;
    endtask
endmodule

// File: dv/serial_port_status_monitor.sv
// Port checker for the serial port status flag block
`timescale 1ns/1ps
`include "serial_port_consts.vh"
module serial_port_status_monitor (
    input wire        pclk,
    input wire        presetn,
    input wire        ce,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        scl_in,
    input wire        sda_in,
    input wire        scl_out,
    input wire        scl_oe,
    input wire        sda_out,
    input wire        sda_oe,
    input wire        port_idle,
    input wire        irq
);
    logic [7:0] ctrl;
    logic [3:0] mask;
    wire        acc    = psel && penable && ce;
    wire        rd_st  = acc && !pwrite && paddr == `REG_STATUS;
    wire        rd_buf = acc && !pwrite && paddr == `REG_BUFFER;
    wire        wr_buf = acc && pwrite && paddr == `REG_BUFFER;
    // Shadow of control and mask, updated on accepted writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= 8'h00;
            mask <= 4'h0;
        end else if (acc && pwrite && paddr == `REG_CONTROL) begin
            ctrl <= pwdata[7:0];
        end else if (acc && pwrite && paddr == `REG_IRQ_MASK) begin
            mask <= pwdata[3:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_excl; rd_st |-> !(prdata[`ST_START] && prdata[`ST_STOP]); endproperty
    a_excl: assert property (p_excl) else $error("start and stop both set");
    property p_off; rd_st && !ctrl[0] && !$past(ctrl[0], 2) |-> prdata[4:3] == 2'b00; endproperty
    a_off: assert property (p_off) else $error("bus flags set while disabled");
    property p_dir; rd_st && prdata[`ST_STOP] && !ctrl[2] |-> !prdata[`ST_RW]; endproperty
    a_dir: assert property (p_dir) else $error("direction kept after stop");
    property p_busy; ctrl[0] && ctrl[2] && ctrl[7:3] != 5'h00 |-> !port_idle; endproperty
    a_busy: assert property (p_busy) else $error("idle with busy bits set");
    property p_rxclr; rd_buf ##3 rd_st |-> !prdata[0]; endproperty
    a_rxclr: assert property (p_rxclr) else $error("full after buffer read");
    property p_txful; wr_buf ##3 rd_st |-> prdata[0]; endproperty
    a_txful: assert property (p_txful) else $error("not full after buffer write");
    property p_mask; mask == 4'h0 |-> !irq; endproperty
    a_mask: assert property (p_mask) else $error("interrupt with all masked");
    property p_slv; psel && penable && paddr > `REG_IRQ_MASK |-> pslverr && pready; endproperty
    a_slv: assert property (p_slv) else $error("unmapped access not refused");
endmodule
bind serial_port_status_flags serial_port_status_monitor mon (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .scl_in, .sda_in,
    .scl_out, .scl_oe, .sda_out, .sda_oe, .port_idle, .irq);

// File: dv/tb_top.sv
// Self-checking bench of the serial port status flag block
`timescale 1ns/1ps
`include "serial_port_consts.vh"
module tb_top;
    localparam logic [6:0] ADDR = 7'h2D;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rs = 32'h2;
    logic [31:0] rd;
    logic [7:0]  v;
    logic [7:0]  rx;
    logic        slv;
    logic        ack;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          m_start = 0;
    int          m_stop = 0;
    int          m_dir = 0;
    int          m_bf = 0;
    logic [7:0]  rxq[$];
    wire  [31:0] prdata;
    wire         pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, port_idle, irq;
    wire         peer_scl, peer_low;
    wire         scl_w = peer_scl && !(scl_oe && !scl_out);
    wire         sda_w = !peer_low && !(sda_oe && !sda_out);
    always #12.5 pclk = ~pclk;
    serial_port_status_flags #(.OWN_ADDR(ADDR)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_w), .sda_in(sda_w),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
        .port_idle(port_idle), .irq(irq));
    i2c_peer peer (.scl(peer_scl), .sda_low(peer_low), .sda(sda_w));
    // Xorshift source for data bytes
    function automatic logic [7:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs[7:0];
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One bus transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Status read against the flag model
    task automatic chk_st();
        apb(1'b0, `REG_STATUS, 32'h0);
        chk(rd & 32'h1D, 32'((m_stop << 4) | (m_start << 3) | (m_dir << 2) | m_bf));
    endtask
    task automatic st(input logic first);
        peer.cond(first);
        @(posedge pclk);
    endtask
    task automatic xf(input logic [7:0] tx, input logic ack_in);
        peer.xfer(tx, ack_in, rx, ack);
        @(posedge pclk);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Cycle ceiling against a hang
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_st();
        apb(1'b0, `REG_CONTROL, 32'h0);
        chk(rd, 32'(`CTRL_RESET));
        apb(1'b1, `REG_STATUS, 32'hFF);
        chk_st();
        apb(1'b0, 12'hFFC, 32'h0);
        chk(32'(slv), 32'h1);
        $display("reset and map test done");
        apb(1'b1, `REG_CONTROL, 32'h03);
        apb(1'b1, `REG_IRQ_MASK, 32'h1 << `IRQ_START);
        apb(1'b0, `REG_IRQ_STATUS, 32'h0);
        st(1'b1);
        m_start = 1;
        chk(32'(irq), 32'h1);
        chk_st();
        apb(1'b0, `REG_IRQ_STATUS, 32'h0);
        chk(rd, 32'h1 << `IRQ_START);
        @(posedge pclk);
        chk(32'(irq), 32'h0);
        $display("start and interrupt test done");
        xf({ADDR, 1'b0}, 1'b1);
        chk(32'(ack), 32'h0);
        chk_st();
        v = xs();
        xf(v, 1'b1);
        rxq.push_back(v);
        m_bf = 1;
        chk_st();
        apb(1'b0, `REG_BUFFER, 32'h0);
        chk(rd, 32'(rxq.pop_front()));
        m_bf = 0;
        chk_st();
        $display("target receive test done");
        st(1'b1);
        v = xs();
        apb(1'b1, `REG_BUFFER, 32'(v));
        m_bf = 1;
        chk_st();
        xf({ADDR, 1'b1}, 1'b1);
        m_dir = 1;
        chk_st();
        xf(8'hFF, 1'b1);
        chk(32'(rx), 32'(v));
        m_bf = 0;
        m_dir = 0;
        chk_st();
        st(1'b0);
        m_start = 0;
        m_stop = 1;
        chk_st();
        $display("target transmit test done");
        apb(1'b1, `REG_IRQ_MASK, 32'h0);
        st(1'b1);
        m_start = 1;
        m_stop = 0;
        chk(32'(irq), 32'h0);
        xf({~ADDR, 1'b0}, 1'b1);
        chk(32'(ack), 32'h1);
        chk_st();
        apb(1'b1, `REG_CONTROL, 32'h0);
        m_start = 0;
        st(1'b0);
        chk_st();
        $display("foreign address and disable test done");
        for (int b = 3; b < 8; b++) begin
            apb(1'b1, `REG_CONTROL, 32'h05 | (32'h1 << b));
            @(posedge pclk);
            chk(32'(port_idle), 32'h0);
        end
        apb(1'b1, `REG_CONTROL, 32'h05);
        @(posedge pclk);
        chk(32'(port_idle), 32'h1);
        chk_st();
        ce <= 1'b0;
        apb(1'b1, `REG_IRQ_MASK, 32'hF);
        ce <= 1'b1;
        apb(1'b0, `REG_IRQ_MASK, 32'h0);
        chk(rd, 32'h0);
        $display("controller and enable test done");
        print_verdict();
    end
endmodule

// File: hdl/bus_cond_detect.v
// Start, stop and clock-edge detection on synchronised bus lines
`timescale 1ns/1ps
module bus_cond_detect (
    input  wire pclk,
    input  wire presetn,
    input  wire ce,
    input  wire scl_s,
    input  wire sda_s,
    output wire scl_rise,
    output wire scl_fall,
    output wire start_seen,
    output wire stop_seen
);
    reg scl_d;
    reg sda_d;

    // Previous sample of each line
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else if (ce) begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // Data line change while clock stays high marks a bus condition
    assign scl_rise   = ce & scl_s & ~scl_d;
    assign scl_fall   = ce & ~scl_s & scl_d;
    assign start_seen = ce & scl_s & scl_d & sda_d & ~sda_s;
    assign stop_seen  = ce & scl_s & scl_d & ~sda_d & sda_s;
endmodule

// File: hdl/pin_sync.v
// Two-stage synchroniser for pins from outside the pclk domain
`timescale 1ns/1ps
module pin_sync #(
    parameter WIDTH = 2
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             ce,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] stage1;

    // First stage only feeds second stage; idle bus level is high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= {WIDTH{1'b1}};
            dout   <= {WIDTH{1'b1}};
        end else if (ce) begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule

// File: hdl/serial_port_consts.vh
// Constants for the serial port status flag block
`ifndef SERIAL_PORT_STATUS_CONSTS_VH
`define SERIAL_PORT_STATUS_CONSTS_VH
// Register byte offsets
`define REG_STATUS        12'h000
`define REG_CONTROL       12'h004
`define REG_BUFFER        12'h008
`define REG_IRQ_STATUS    12'h00C
`define REG_IRQ_MASK      12'h010
// Status field positions
`define ST_BF             0
`define ST_UA             1
`define ST_RW             2
`define ST_START          3
`define ST_STOP           4
// Control field positions
`define CT_ENABLE         0
`define CT_I2C            1
`define CT_CONTROLLER     2
`define CT_SEN            3
`define CT_RESTART_COND_ENABLE           4
`define CT_PEN            5
`define CT_RCEN           6
`define CT_ACKEN          7
// Interrupt event bits
`define IRQ_START         0
`define IRQ_STOP          1
`define IRQ_RXFULL        2
`define IRQ_ADDR          3
`define IRQ_WIDTH         4
// Reset values
`define CTRL_RESET        8'h00
`define MASK_RESET        4'h0
`define ADDR_RESET        7'h42
`endif

// File: hdl/serial_port_status_flags.v
// Serial port status flags with APB registers and interrupt
`timescale 1ns/1ps
`include "serial_port_consts.vh"
module serial_port_status_flags #(
    parameter [6:0] OWN_ADDR = `ADDR_RESET
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        scl_out,
    output wire        scl_oe,
    output wire        sda_out,
    output wire        sda_oe,
    output wire        port_idle,
    output wire        irq
);
    localparam ST_IDLE = 2'b00;
    localparam ST_BITS = 2'b01;
    localparam ST_ACK  = 2'b10;

    wire       scl_s;
    wire       sda_s;
    wire       scl_rise;
    wire       scl_fall;
    wire       start_seen;
    wire       stop_seen;
    reg  [7:0] control;
    reg  [3:0] irq_mask;
    reg  [3:0] irq_stat;
    reg        start_flag;
    reg        stop_flag;
    reg        rw_flag;
    reg        bf_flag;
    reg        ua_flag;
    reg  [7:0] shift_data_buffer;
    reg  [7:0] shreg;
    reg  [3:0] bit_cnt;
    reg  [1:0] state;
    reg        addr_phase;
    reg        addressed;
    reg        ack_drive;
    reg        tx_mode;
    reg  [3:0] next_irq;
    reg  [7:0] next_shreg;

    wire port_enable_bit = control[`CT_ENABLE];
    wire i2c_mode        = control[`CT_I2C];
    wire controller      = control[`CT_CONTROLLER];
    wire wr_en = psel & penable & pwrite & ce;
    wire rd_en = psel & penable & ~pwrite & ce;

    // Bus line synchronisers
    pin_sync #(
        .WIDTH (2)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .din     ({scl_in, sda_in}),
        .dout    ({scl_s, sda_s})
    );

    // Bus condition detection
    bus_cond_detect u_det (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .scl_s      (scl_s),
        .sda_s      (sda_s),
        .scl_rise   (scl_rise),
        .scl_fall   (scl_fall),
        .start_seen (start_seen),
        .stop_seen  (stop_seen)
    );

    // Address decode, used by the valid check only
    function addr_known;
        input [11:0] a;
        begin
            if (a == `REG_STATUS) begin
                addr_known = 1'b1;
            end else if (a == `REG_CONTROL) begin
                addr_known = 1'b1;
            end else if (a == `REG_BUFFER) begin
                addr_known = 1'b1;
            end else if (a == `REG_IRQ_STATUS) begin
                addr_known = 1'b1;
            end else if (a == `REG_IRQ_MASK) begin
                addr_known = 1'b1;
            end else begin
                addr_known = 1'b0;
            end
        end
    endfunction

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_known(paddr);

    // Control and mask registers written by software
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control  <= `CTRL_RESET;
            irq_mask <= `MASK_RESET;
        end else if (wr_en) begin
            if (paddr == `REG_CONTROL) begin
                control <= pwdata[7:0];
            end else if (paddr == `REG_IRQ_MASK) begin
                irq_mask <= pwdata[`IRQ_WIDTH-1:0];
            end
        end
    end

    // Start and stop flags follow the most recent bus condition
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_flag <= 1'b0;
            stop_flag  <= 1'b0;
        end else if (ce) begin
            if (!port_enable_bit || !i2c_mode) begin
                start_flag <= 1'b0;
                stop_flag  <= 1'b0;
            end else if (start_seen) begin
                start_flag <= 1'b1;
                stop_flag  <= 1'b0;
            end else if (stop_seen) begin
                start_flag <= 1'b0;
                stop_flag  <= 1'b1;
            end
        end
    end

    // Shift register next value, sampled on rising clock
    always @* begin
        next_shreg = {shreg[6:0], sda_s};
    end

    // Byte engine: shifts bits, tracks address, direction and ack
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= ST_IDLE;
            shreg      <= 8'h00;
            bit_cnt    <= 4'h0;
            addr_phase <= 1'b0;
            addressed  <= 1'b0;
            ack_drive  <= 1'b0;
            rw_flag    <= 1'b0;
            ua_flag    <= 1'b0;
            tx_mode    <= 1'b0;
            shift_data_buffer <= 8'h00;
        end else if (ce) begin
            if (!port_enable_bit || !i2c_mode) begin
                state     <= ST_IDLE;
                addressed <= 1'b0;
                ack_drive <= 1'b0;
                rw_flag   <= 1'b0;
            end else if (start_seen || stop_seen) begin
                state      <= start_seen ? ST_BITS : ST_IDLE;
                bit_cnt    <= 4'h0;
                addr_phase <= start_seen;
                addressed  <= 1'b0;
                ack_drive  <= 1'b0;
                tx_mode    <= 1'b0;
                rw_flag    <= 1'b0;
            end else begin
                case (state)
                    ST_BITS: begin
                        if (scl_rise) begin
                            if (!tx_mode) begin
                                shreg <= next_shreg;
                            end
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && tx_mode && bit_cnt != 4'h0
                                     && bit_cnt != 4'h8) begin
                            // Next transmit bit moves out only while the clock is low
                            shreg <= {shreg[6:0], 1'b1};
                        end else if (scl_fall && bit_cnt == 4'h8) begin
                            state   <= ST_ACK;
                            bit_cnt <= 4'h0;
                            if (addr_phase) begin
                                addressed <= (shreg[7:1] == OWN_ADDR);
                                ack_drive <= (shreg[7:1] == OWN_ADDR);
                                ua_flag   <= (shreg[7:1] == OWN_ADDR);
                                if (shreg[7:1] == OWN_ADDR) begin
                                    rw_flag <= shreg[0];
                                    tx_mode <= shreg[0];
                                end
                            end else if (addressed && !tx_mode) begin
                                shift_data_buffer <= shreg;
                                ack_drive <= 1'b1;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_rise && tx_mode && !addr_phase && sda_s) begin
                            rw_flag <= 1'b0;
                            addressed <= 1'b0;
                        end
                        if (scl_fall) begin
                            ack_drive  <= 1'b0;
                            addr_phase <= 1'b0;
                            state      <= addressed ? ST_BITS : ST_IDLE;
                            if (tx_mode) begin
                                shreg <= shift_data_buffer;
                            end
                        end
                    end
                    default: begin
                        state <= ST_IDLE;
                    end
                endcase
                if (wr_en && paddr == `REG_BUFFER) begin
                    shift_data_buffer <= pwdata[7:0];
                end
                if (rd_en && paddr == `REG_STATUS) begin
                    ua_flag <= 1'b0;
                end
            end
        end
    end

    // Buffer full: set on reception or software load, cleared on read outside transmit or at shift end in transmit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bf_flag <= 1'b0;
        end else if (ce) begin
            if (state == ST_BITS && scl_fall && bit_cnt == 4'h8 && addressed
                && !tx_mode && !addr_phase) begin
                bf_flag <= 1'b1;
            end else if (wr_en && paddr == `REG_BUFFER) begin
                bf_flag <= 1'b1;
            end else if (state == ST_BITS && scl_fall && bit_cnt == 4'h8 && tx_mode) begin
                bf_flag <= 1'b0;
            end else if (rd_en && paddr == `REG_BUFFER && !tx_mode) begin
                bf_flag <= 1'b0;
            end
        end
    end

    // Transmit data drives the line in read transfers, ack otherwise
    assign sda_oe  = ack_drive | (tx_mode && addressed && state == ST_BITS && !shreg[7]);
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    assign scl_oe  = 1'b0;

    // Idle when no busy bit is set
    assign port_idle = ~((controller ? (state != ST_IDLE) : rw_flag)
                       | control[`CT_SEN] | control[`CT_RESTART_COND_ENABLE] | control[`CT_PEN]
                       | control[`CT_RCEN] | control[`CT_ACKEN]);

    // Sticky interrupt events; set wins over read clear
    always @* begin
        next_irq = irq_stat;
        if (rd_en && paddr == `REG_IRQ_STATUS) begin
            next_irq = 4'h0;
        end
        if (port_enable_bit && i2c_mode) begin
            next_irq[`IRQ_START]  = next_irq[`IRQ_START] | start_seen;
            next_irq[`IRQ_STOP]   = next_irq[`IRQ_STOP] | stop_seen;
        end
        next_irq[`IRQ_RXFULL] = next_irq[`IRQ_RXFULL] | (state == ST_BITS && scl_fall
                                && bit_cnt == 4'h8 && addressed && !tx_mode && !addr_phase);
        next_irq[`IRQ_ADDR] = next_irq[`IRQ_ADDR] | (state == ST_BITS && scl_fall
                              && bit_cnt == 4'h8 && addr_phase && shreg[7:1] == OWN_ADDR);
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= 4'h0;
        end else if (ce) begin
            irq_stat <= next_irq;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // Read data register; status bit 2 is direction in target mode, busy in controller
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (ce && psel && !penable && !pwrite) begin
            prdata <= 32'h00000000;
            if (paddr == `REG_STATUS) begin
                prdata[`ST_BF]    <= bf_flag;
                prdata[`ST_UA]    <= ua_flag;
                prdata[`ST_RW]    <= controller ? (state != ST_IDLE) : rw_flag;
                prdata[`ST_START] <= start_flag;
                prdata[`ST_STOP]  <= stop_flag;
            end else if (paddr == `REG_CONTROL) begin
                prdata[7:0] <= control;
            end else if (paddr == `REG_BUFFER) begin
                prdata[7:0] <= shift_data_buffer;
            end else if (paddr == `REG_IRQ_STATUS) begin
                prdata[`IRQ_WIDTH-1:0] <= irq_stat;
            end else if (paddr == `REG_IRQ_MASK) begin
                prdata[`IRQ_WIDTH-1:0] <= irq_mask;
            end
        end
    end
endmodule
